// ---- logic/irq_route_pkg.sv ----
package irq_route_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SRC_ENABLE  = 8'h2D;
  localparam logic [7:0] ADDR_PIN_ROUTING = 8'h2E;
  localparam logic [7:0] ADDR_SYS_MODE    = 8'h0B;
  localparam logic [7:0] ADDR_INT_SOURCE  = 8'h0C;
  localparam logic [7:0] ADDR_MAG_THS_CFG = 8'h52;
  localparam logic [7:0] ADDR_MAG_VEC_CFG = 8'h69;
  localparam logic [7:0] ADDR_INT_CTRL    = 8'h2C;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'hF0;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'hF1;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_ASLP       = 7;
  localparam int unsigned NUM_ACC_SRC    = 8;
  localparam int unsigned BIT_MAG_EN     = 0;
  localparam int unsigned BIT_MAG_ROUTE  = 1;
  localparam int unsigned BIT_IPOL       = 1;
  localparam int unsigned BIT_SYSMODE_LO = 0;
  // status event bits: 0 first pin went active, 1 second pin went active, 2 mode change
  localparam int unsigned EVT_FIRST      = 0;
  localparam int unsigned EVT_SECOND     = 1;
  localparam int unsigned EVT_MODE       = 2;
  localparam int unsigned NUM_EVT        = 3;
endpackage : irq_route_pkg

// ---- logic/pin_tree.sv ----
`timescale 1ns/1ps
// gates each flag by its enable and splits it onto two or-trees
module pin_tree #(
  parameter int unsigned N = 10
) (
  input  wire logic [N-1:0] flag_in,
  input  wire logic [N-1:0] enable_in,
  input  wire logic [N-1:0] route_in,
  output logic              first_out,
  output logic              second_out
);
  // one source at least, else the or trees have nothing to reduce
  if (N < 1) begin : g_width_check
    $error("pin_tree needs at least one source");
  end
  wire [N-1:0] gated = flag_in & enable_in;
  // ----------------------------------------------------------------
  // or trees
  // ----------------------------------------------------------------
  // route bit steering
  assign first_out  = |(gated & route_in);
  assign second_out = |(gated & ~route_in);
endmodule : pin_tree

// ---- logic/irq_route.sv ----
`timescale 1ns/1ps
// Operation
// - source enable register at 0x2D, eight sources, resets to zero
// - enable one passes the source flag, zero blocks it from both pins and int source, but not from the mode status event
// - routing register at 0x2E, same bit order, resets to zero
// - routing zero steers to second pin, one to first pin
// - each pin is the or of enabled sources steered to it
// - magnetic enables come from registers 0x52 and 0x69
// - magnetic routing bits in 0x52 and 0x69 join the same trees
// - polarity bit: zero active low by default, one active high
// - mode-change interrupt raised per transition, cleared by reading 0x0B
module irq_route
  import irq_route_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic [6:0] acc_flag_in,
  input  wire logic       mag_ths_flag_in,
  input  wire logic       mag_vec_flag_in,
  input  wire logic       sleep_mode_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            first_irq_pin_out,
  output logic            second_irq_pin_out,
  output logic            irq_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]         interrupt_source_enable;
  logic [7:0]         interrupt_pin_routing;
  logic [1:0]         mag_ths_cfg;
  logic [1:0]         mag_vec_cfg;
  logic [1:0]         int_ctrl;
  logic [NUM_EVT-1:0] evt_status;
  logic [NUM_EVT-1:0] evt_mask;
  logic               mode_irq;
  logic               sleep_q;
  logic               first_q;
  logic               second_q;

  // status field and read mux pack the event bits into one byte
  if (NUM_EVT != 3) begin : g_evt_width
    $error("irq_route serves exactly three status event bits");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // strobes gated by the clock enable, so a frozen block ignores the bus
  wire wr_en   = ce_in && wr_in && (addr_in == ADDR_SRC_ENABLE);
  wire wr_rt   = ce_in && wr_in && (addr_in == ADDR_PIN_ROUTING);
  wire wr_mth  = ce_in && wr_in && (addr_in == ADDR_MAG_THS_CFG);
  wire wr_mvc  = ce_in && wr_in && (addr_in == ADDR_MAG_VEC_CFG);
  wire wr_ctl  = ce_in && wr_in && (addr_in == ADDR_INT_CTRL);
  wire wr_st   = ce_in && wr_in && (addr_in == ADDR_EVT_STATUS);
  wire wr_msk  = ce_in && wr_in && (addr_in == ADDR_EVT_MASK);
  wire rd_mode = ce_in && rd_in && (addr_in == ADDR_SYS_MODE);

  // mode change detected on an edge of the same-clock sleep level
  wire mode_edge = ce_in && (sleep_mode_in != sleep_q);

  // ----------------------------------------------------------------
  // source vectors: seven acceleration sources, the mode interrupt, then two magnetic
  // ----------------------------------------------------------------
  wire [9:0] all_flag  = {mag_vec_flag_in, mag_ths_flag_in, mode_irq, acc_flag_in};
  wire [9:0] all_en    = {mag_vec_cfg[BIT_MAG_EN], mag_ths_cfg[BIT_MAG_EN],
                          interrupt_source_enable};
  wire [9:0] all_route = {mag_vec_cfg[BIT_MAG_ROUTE], mag_ths_cfg[BIT_MAG_ROUTE],
                          interrupt_pin_routing};
  wire       first_raw;
  wire       second_raw;

  pin_tree #(
    .N (10)
  ) u_tree (
    .flag_in    (all_flag),
    .enable_in  (all_en),
    .route_in   (all_route),
    .first_out  (first_raw),
    .second_out (second_raw)
  );

  wire [NUM_EVT-1:0] evt_set;
  assign evt_set[EVT_FIRST]  = ce_in && first_raw && !first_q;
  assign evt_set[EVT_SECOND] = ce_in && second_raw && !second_q;
  assign evt_set[EVT_MODE]   = mode_edge;
  wire [NUM_EVT-1:0] evt_clr = wr_st ? wdata_in[NUM_EVT-1:0] : '0;

  // ----------------------------------------------------------------
  // read mux: int source shows which enabled acceleration and mode sources are active
  // ----------------------------------------------------------------
  wire [7:0] src_view = all_flag[7:0] & interrupt_source_enable;
  // unmapped addresses read as zero, so a stray read never shows stale data
  wire [7:0] rd_mux =
    (addr_in == ADDR_SRC_ENABLE)  ? interrupt_source_enable :
    (addr_in == ADDR_PIN_ROUTING) ? interrupt_pin_routing :
    (addr_in == ADDR_MAG_THS_CFG) ? {6'h00, mag_ths_cfg} :
    (addr_in == ADDR_MAG_VEC_CFG) ? {6'h00, mag_vec_cfg} :
    (addr_in == ADDR_INT_CTRL)    ? {6'h00, int_ctrl} :
    (addr_in == ADDR_INT_SOURCE)  ? src_view :
    (addr_in == ADDR_SYS_MODE)    ? {7'h00, sleep_q} :
    (addr_in == ADDR_EVT_STATUS)  ? {5'h00, evt_status} :
    (addr_in == ADDR_EVT_MASK)    ? {5'h00, evt_mask} : RESET_BYTE;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // enable, routing, magnetic, control and mask register storage
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      interrupt_source_enable <= RESET_BYTE;
      interrupt_pin_routing   <= RESET_BYTE;
      mag_ths_cfg             <= '0;
      mag_vec_cfg             <= '0;
      int_ctrl                <= '0;
      evt_mask                <= '0;
    end else begin
      if (wr_en)  interrupt_source_enable <= wdata_in;
      if (wr_rt)  interrupt_pin_routing <= wdata_in;
      if (wr_mth) mag_ths_cfg <= wdata_in[1:0];
      if (wr_mvc) mag_vec_cfg <= wdata_in[1:0];
      if (wr_ctl) int_ctrl <= wdata_in[1:0];
      if (wr_msk) evt_mask <= wdata_in[NUM_EVT-1:0];
    end
  end

  // detector starts at the idle sleep level, so reset leaves no false edge
  // mode interrupt, set wins over read clear
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mode_irq <= 1'b0;
      sleep_q  <= 1'b0;
    end else if (ce_in) begin
      sleep_q  <= sleep_mode_in;
      mode_irq <= mode_edge ? 1'b1 : (rd_mode ? 1'b0 : mode_irq);
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      evt_status <= '0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end

  // ----------------------------------------------------------------
  // outputs, pins one register stage behind the trees, irq_out two stages behind
  // ----------------------------------------------------------------
  // pins leave flops directly, so the host never sees a tree glitch
  // polarity applied on the pin drive
  // gated level reaches pins next edge
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      first_q            <= 1'b0;
      second_q           <= 1'b0;
      first_irq_pin_out  <= 1'b1;
      second_irq_pin_out <= 1'b1;
      irq_out            <= 1'b0;
      rdata_out          <= RESET_BYTE;
    end else if (ce_in) begin
      first_q            <= first_raw;
      second_q           <= second_raw;
      first_irq_pin_out  <= first_raw ~^ int_ctrl[BIT_IPOL];
      second_irq_pin_out <= second_raw ~^ int_ctrl[BIT_IPOL];
      irq_out            <= |(evt_status & evt_mask);
      rdata_out          <= rd_in ? rd_mux : RESET_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // reference ors built apart from the tree instance, so a tree fault shows
  wire first_ref  = |(all_flag & all_en & all_route);
  wire second_ref = |(all_flag & all_en & ~all_route);
  wire irq_ref    = |(evt_status & evt_mask);
  wire ipol_ref   = int_ctrl[BIT_IPOL];
  wire rd_src_en  = ce_in && rd_in && (addr_in == ADDR_SRC_ENABLE);

  disabled_quiet_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && (all_en == '0) && !int_ctrl[BIT_IPOL] |=> first_irq_pin_out && second_irq_pin_out)
    else $error("disabled sources reached a pin");
  route_first_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && all_flag[0] && all_en[0] && all_route[0] |=>
      first_irq_pin_out == int_ctrl[BIT_IPOL] || $past(wr_ctl))
    else $error("route one missed first pin");
  second_or_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in |=> second_irq_pin_out == ($past(second_ref) ~^ $past(ipol_ref)))
    else $error("second pin not or of its sources");
  first_or_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in |=> first_irq_pin_out == ($past(first_ref) ~^ $past(ipol_ref)))
    else $error("first pin not or of its sources");
  enable_reset_a: assert property (@(posedge clk_sys_in)
    srst_in |=> interrupt_source_enable == 8'h00 && interrupt_pin_routing == 8'h00)
    else $error("config not zero after reset");
  mode_set_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    mode_edge |=> mode_irq)
    else $error("mode change lost");
  mode_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rd_mode && !mode_edge |=> !mode_irq)
    else $error("mode read did not clear");
  routing_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_rt |=> interrupt_pin_routing == $past(wdata_in))
    else $error("routing write lost");
  idle_level_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && !first_raw && !wr_ctl ##1 ce_in |-> first_irq_pin_out == !int_ctrl[BIT_IPOL])
    else $error("idle pin level wrong");
  both_pins_c: cover property (@(posedge clk_sys_in) first_raw && second_raw);
  mode_irq_c:  cover property (@(posedge clk_sys_in) mode_edge ##[1:20] rd_mode);
  irq_out_c:   cover property (@(posedge clk_sys_in) irq_out);
  ce_off_c:    cover property (@(posedge clk_sys_in) !ce_in && wr_in);
  mag_first_c: cover property (@(posedge clk_sys_in) mag_ths_flag_in && mag_ths_cfg == 2'h3);

  // ----------------------------------------------------------------
  // assertions: register file and read port
  // ----------------------------------------------------------------
  // enable write
  enable_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_en |=> interrupt_source_enable == $past(wdata_in))
    else $error("enable write lost");
  enable_read_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rd_src_en |=> rdata_out == $past(interrupt_source_enable))
    else $error("enable readback wrong");
  // read data stands for one cycle only
  read_idle_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && !rd_in |=> rdata_out == RESET_BYTE)
    else $error("read data outlived its cycle");
  mode_read_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rd_mode |=> rdata_out == {7'h00, $past(sleep_q)})
    else $error("system mode readback wrong");
  // frozen clock enable holds every output
  ce_freeze_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !ce_in |=> $stable(first_irq_pin_out) && $stable(second_irq_pin_out) &&
      $stable(irq_out) && $stable(rdata_out) && $stable(evt_status))
    else $error("state moved with clock enable low");

  // ----------------------------------------------------------------
  // assertions: pins, polarity and magnetic sources
  // ----------------------------------------------------------------
  // pins idle after reset
  pin_reset_a: assert property (@(posedge clk_sys_in)
    srst_in |=> first_irq_pin_out && second_irq_pin_out && !irq_out)
    else $error("pins not idle after reset");
  first_low_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && first_raw && !ipol_ref |=> !first_irq_pin_out)
    else $error("first pin not driven low");
  second_high_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && second_raw && ipol_ref |=> second_irq_pin_out)
    else $error("second pin not driven high");
  // route zero reaches the second pin
  route_second_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && all_flag[0] && all_en[0] && !all_route[0] |=>
      second_irq_pin_out == $past(ipol_ref))
    else $error("route zero missed second pin");
  // magnetic threshold steered to the first pin
  mag_first_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && mag_ths_flag_in && (mag_ths_cfg == 2'h3) |=>
      first_irq_pin_out == $past(ipol_ref))
    else $error("magnetic threshold missed first pin");
  // magnetic magnitude enabled onto the second pin
  mag_second_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in && mag_vec_flag_in && (mag_vec_cfg == 2'h1) |=>
      second_irq_pin_out == $past(ipol_ref))
    else $error("magnetic magnitude missed second pin");

  // ----------------------------------------------------------------
  // assertions: sticky events and the mode interrupt
  // ----------------------------------------------------------------
  // mode interrupt holds between set and read
  mode_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !mode_edge && !rd_mode |=> mode_irq == $past(mode_irq))
    else $error("mode interrupt moved by itself");
  // every event sets its status bit, even beside a clear
  status_set_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (|evt_set) |=> (evt_status & $past(evt_set)) == $past(evt_set))
    else $error("status event lost");
  // write one clears a status bit that no event sets
  status_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (|evt_clr) && ((evt_set & evt_clr) == '0) |=> (evt_status & $past(evt_clr)) == '0)
    else $error("status clear ignored");
  // interrupt output follows the masked status
  irq_level_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ce_in |=> irq_out == $past(irq_ref))
    else $error("irq output not masked status");
endmodule : irq_route

// ---- testbench/irq_host.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the two interrupt lines
// ------------------------------------------------------------
module irq_host (
  input  wire logic ipol_in,
  input  wire logic first_pin_in,
  input  wire logic second_pin_in,
  output logic      first_seen_out,
  output logic      second_seen_out
);
  // host must know the programmed polarity, else it reads idle as busy
  // polarity decode
  assign first_seen_out  = (first_pin_in == ipol_in);
  assign second_seen_out = (second_pin_in == ipol_in);
endmodule : irq_host

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import irq_route_pkg::*;
  logic       clk_sys_in = 0, srst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0;
  logic [6:0] acc_flag_in = 0, fl;
  logic       mag_ths_flag_in = 0, mag_vec_flag_in = 0, sleep_mode_in = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, en, rt;
  logic       first_irq_pin_out, second_irq_pin_out, irq_out, f_seen, s_seen;
  logic       ipol = 0, rd_seen = 0, look_on = 0;
  logic [7:0] rd_q[$];
  logic [2:0] pin_q[$];
  int         num_errors = 0, cmp_count = 0;
  integer     seed = 32'h3edd;

  always #5 clk_sys_in = ~clk_sys_in;

  irq_route dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in),
    .acc_flag_in(acc_flag_in), .mag_ths_flag_in(mag_ths_flag_in),
    .mag_vec_flag_in(mag_vec_flag_in), .sleep_mode_in(sleep_mode_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .first_irq_pin_out(first_irq_pin_out), .second_irq_pin_out(second_irq_pin_out),
    .irq_out(irq_out));
  irq_host host (.ipol_in(ipol), .first_pin_in(first_irq_pin_out),
    .second_pin_in(second_irq_pin_out), .first_seen_out(f_seen), .second_seen_out(s_seen));

  // ------------------------------------------------------------
  // driver tasks: one bus cycle per edge, no strobe set twice
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
  endtask : bus
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wrt
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  // settle time covers pin, status and irq register stages
  task automatic look(input logic [2:0] e);
    repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
    pin_q.push_back(e);
    look_on <= 1'b1;
    @(posedge clk_sys_in);
    look_on <= 1'b0;
  endtask : look
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clk_sys_in) rd_seen <= rd_in;
  always @(negedge clk_sys_in) begin
    if (rd_seen && rd_q.size() > 0) chk("rdata", rdata_out, rd_q.pop_front());
    if (look_on && pin_q.size() > 0)
      chk("pins", {5'b0, f_seen, s_seen, irq_out}, {5'b0, pin_q.pop_front()});
  end

  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd(ADDR_SRC_ENABLE, RESET_BYTE);
    rd(ADDR_PIN_ROUTING, RESET_BYTE);
    rd(8'h77, 8'h00);
    look(3'b000);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      en = 8'($random(seed));
      rt = 8'($random(seed));
      fl = 7'($random(seed));
      acc_flag_in <= fl;
      wrt(ADDR_SRC_ENABLE, en);
      wrt(ADDR_PIN_ROUTING, rt);
      look({|(fl & en[6:0] & rt[6:0]), |(fl & en[6:0] & ~rt[6:0]), 1'b0});
      rd(ADDR_SRC_ENABLE, en);
      rd(ADDR_PIN_ROUTING, rt);
      rd(ADDR_INT_SOURCE, {1'b0, fl & en[6:0]});
    end
    $display("test routing done");
    acc_flag_in <= 7'h7f;
    wrt(ADDR_SRC_ENABLE, 8'h00);
    look(3'b000);
    acc_flag_in <= 7'h00;
    for (int m = 0; m < 8; m++) begin
      mag_ths_flag_in <= ~m[2];
      mag_vec_flag_in <= m[2];
      wrt(m[2] ? ADDR_MAG_VEC_CFG : ADDR_MAG_THS_CFG, {6'h00, m[1:0]});
      look({m[1:0] == 2'd3, m[1:0] == 2'd1, 1'b0});
    end
    mag_ths_flag_in <= 1'b0;
    mag_vec_flag_in <= 1'b0;
    $display("test magnetic done");
    ipol <= 1'b1;
    wrt(ADDR_INT_CTRL, 8'h02);
    look(3'b000);
    acc_flag_in <= 7'h01;
    wrt(ADDR_SRC_ENABLE, 8'h01);
    wrt(ADDR_PIN_ROUTING, 8'h01);
    look(3'b100);
    wrt(ADDR_PIN_ROUTING, 8'h00);
    look(3'b010);
    $display("test polarity done");
    acc_flag_in <= 7'h00;
    wrt(ADDR_SRC_ENABLE, 8'h80);
    wrt(ADDR_PIN_ROUTING, 8'h80);
    wrt(ADDR_EVT_STATUS, 8'h07);
    wrt(ADDR_EVT_MASK, 8'h01);
    look(3'b000);
    sleep_mode_in <= 1'b1;
    look(3'b101);
    rd(ADDR_INT_SOURCE, 8'h80);
    rd(ADDR_EVT_STATUS, 8'h05);
    rd(ADDR_SYS_MODE, 8'h01);
    look(3'b001);
    wrt(ADDR_EVT_MASK, 8'h00);
    look(3'b000);
    wrt(ADDR_EVT_MASK, 8'h01);
    look(3'b001);
    wrt(ADDR_EVT_STATUS, 8'h01);
    look(3'b000);
    rd(ADDR_EVT_STATUS, 8'h04);
    $display("test mode irq done");
    // a write with the clock enable low must leave the register alone
    ce_in <= 1'b0;
    wrt(ADDR_SRC_ENABLE, 8'hff);
    ce_in <= 1'b1;
    rd(ADDR_SRC_ENABLE, 8'h80);
    look(3'b000);
    $display("test clock enable done");
    finish_test();
  end
endmodule : tb
